/* File: pkg/mubk_pkg.sv */
// Constants, types and register map of the multi-mode serial bank controller.
// Assumes a 20 MHz core clock and a byte-wide register window of eight offsets.
package mubk_pkg;
	localparam int CLK_HZ = 20_000_000;
	localparam int OVERSAMPLE = 16;
	localparam int LEGACY_MAX_BPS = 115_200;
	localparam int EXT_MAX_BPS = 1_500_000;
	localparam int DIV_MIN_LEGACY_I = (CLK_HZ + OVERSAMPLE * LEGACY_MAX_BPS - 1)
		/ (OVERSAMPLE * LEGACY_MAX_BPS);
	localparam int DIV_MIN_EXT_I = (CLK_HZ + OVERSAMPLE * EXT_MAX_BPS - 1)
		/ (OVERSAMPLE * EXT_MAX_BPS);
	localparam logic [15:0] DIV_MIN_LEGACY = 16'(DIV_MIN_LEGACY_I);
	localparam logic [15:0] DIV_MIN_EXT = 16'(DIV_MIN_EXT_I);
	localparam int ASK_CARRIER_HZ = 500_000;
	localparam logic [4:0] ASK_HALF_CYC = 5'(CLK_HZ / (2 * ASK_CARRIER_HZ));
	localparam int TIMER_RES_US = 125;
	localparam logic [11:0] TIMER_PRESC_CYC = 12'(CLK_HZ / 1_000_000 * TIMER_RES_US);
	localparam logic [3:0] SIR_PULSE_TICKS = 4'h3;
	localparam logic [3:0] MID_TICK = 4'h7;
	localparam logic [3:0] LAST_TICK = 4'hf;
	localparam logic [4:0] STRETCH_TICKS = 5'(OVERSAMPLE);
	localparam logic [2:0] LAST_IDX_MIN = 3'h4;
	localparam int FIFO_MAX = 32;
	localparam logic [5:0] FIFO_LVL_LEGACY = 6'h01;
	localparam logic [5:0] FIFO_LVL_SMALL = 6'h10;
	localparam logic [5:0] FIFO_LVL_MAX = 6'h20;
	typedef logic [2:0] mubk_addr_t;
	// Banks.
	localparam logic [2:0] BANK_MAIN = 3'h0;
	localparam logic [2:0] BANK_LEGACY = 3'h1;
	localparam logic [2:0] BANK_EXT = 3'h2;
	localparam logic [2:0] BANK_REV = 3'h3;
	localparam logic [2:0] BANK_TIMER = 3'h4;
	localparam logic [2:0] BANK_IRCTL = 3'h5;
	localparam logic [2:0] BANK_CIR = 3'h7;
	localparam logic [1:0] CIR_IDX = 2'h2;
	// Offsets.
	localparam mubk_addr_t OFS_BANK_SEL = 3'h3;
	localparam mubk_addr_t OFS_DATA = 3'h0;
	localparam mubk_addr_t OFS_MODE = 3'h1;
	localparam mubk_addr_t OFS_FIFO_CTL = 3'h2;
	localparam mubk_addr_t OFS_LINE_CTL = 3'h4;
	localparam mubk_addr_t OFS_LINE_STAT = 3'h5;
	localparam mubk_addr_t OFS_SCRATCH = 3'h7;
	localparam mubk_addr_t OFS_DIV_LO = 3'h0;
	localparam mubk_addr_t OFS_DIV_HI = 3'h1;
	localparam mubk_addr_t OFS_REV = 3'h0;
	localparam mubk_addr_t OFS_TMR_LO = 3'h0;
	localparam mubk_addr_t OFS_TMR_HI = 3'h1;
	localparam mubk_addr_t OFS_TMR_CTL = 3'h2;
	localparam mubk_addr_t OFS_FLEN_LO = 3'h4;
	localparam mubk_addr_t OFS_FLEN_HI = 3'h5;
	localparam mubk_addr_t OFS_IR_CFG = 3'h0;
	localparam mubk_addr_t OFS_CIR_STAT = 3'h1;
	// Field positions.
	localparam int MODE_EXT_BIT = 0;
	localparam int MODE_SEL_LO = 1;
	localparam int MODE_SEL_HI = 3;
	localparam int MODE_EXTMOD_BIT = 4;
	localparam int FIFO_EN_BIT = 0;
	localparam int FIFO_RXCLR_BIT = 1;
	localparam int FIFO_TXCLR_BIT = 2;
	localparam int FIFO_DEPTH_BIT = 5;
	localparam int LCR_WL_HI = 1;
	localparam int LCR_PEN_BIT = 2;
	localparam int LCR_EPS_BIT = 3;
	localparam int TMR_EN_BIT = 0;
	localparam int CIR_TX_BIT = 0;
	// Reset values.
	localparam logic [2:0] RST_BANK = 3'h0;
	localparam logic [3:0] RST_LCR = 4'h3;
	localparam logic [15:0] RST_DIV = 16'h000c;
	localparam logic [1:0] SYNC_IDLE = 2'h1;
	typedef enum logic [2:0] {
		MODE_UART = 3'h0,
		MODE_ASK = 3'h1,
		MODE_SIR = 3'h2,
		MODE_MIR = 3'h3,
		MODE_FIR = 3'h4,
		MODE_CIR = 3'h5
	} mubk_mode_t;
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_START = 3'h1,
		ST_DATA = 3'h3,
		ST_PARITY = 3'h2,
		ST_STOP = 3'h6
	} mubk_ser_state_t;
endpackage

/* File: pkg/mubk_fifo_if.sv */
// Signals between the core and one of its byte queues.
// Assumes the owner drives requests and the store answers combinationally.
interface mubk_fifo_if;
	logic push;
	logic pop;
	logic clr;
	logic enable;
	logic depth32;
	logic full;
	logic empty;
	logic [7:0] wdata;
	logic [7:0] rdata;
	modport owner(output push, pop, clr, enable, depth32, wdata, input full, empty, rdata);
	modport store(input push, pop, clr, enable, depth32, wdata, output full, empty, rdata);
endinterface

/* File: core/mubk_fifo.sv */
// Byte queue whose usable depth is one, sixteen or thirty-two entries.
// Assumes push is never issued while full; such a push is dropped.
module mubk_fifo
	import mubk_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	mubk_fifo_if.store fifo
);
	logic [7:0] mem_r [FIFO_MAX];
	logic [4:0] wp_r;
	logic [4:0] rp_r;
	logic [5:0] cnt_r;
	// A disabled queue acts as a single holding register.
	wire [5:0] limit = !fifo.enable ? FIFO_LVL_LEGACY :
		(fifo.depth32 ? FIFO_LVL_MAX : FIFO_LVL_SMALL);
	wire do_push = fifo.push && (cnt_r < limit);
	wire do_pop = fifo.pop && (cnt_r != 6'h00);
	assign fifo.full = cnt_r >= limit;
	assign fifo.empty = cnt_r == 6'h00;
	assign fifo.rdata = mem_r[rp_r];
	always_ff @(posedge sys_clk_i) begin
		if (ce_i && do_push) begin
			mem_r[wp_r] <= fifo.wdata;
		end
	end
	always_ff @(posedge sys_clk_i) begin
		if (rst_i || (ce_i && fifo.clr)) begin
			wp_r <= 5'h00;
			rp_r <= 5'h00;
			cnt_r <= 6'h00;
		end else if (ce_i) begin
			wp_r <= wp_r + 5'(do_push);
			rp_r <= rp_r + 5'(do_pop);
			cnt_r <= cnt_r + 6'(do_push) - 6'(do_pop);
		end
	end
endmodule // mubk_fifo

/* File: core/mubk_timer.sv */
// Twelve-bit down timer with a fixed resolution prescaler.
// Assumes load and enable come from logic on the same clock.
module mubk_timer
	import mubk_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic en_i,
	input wire logic load_i,
	input wire logic [11:0] reload_i,
	output logic [11:0] count_o,
	output logic expired_o
);
	logic [11:0] presc_r;
	wire step = en_i && (presc_r == 12'h000);
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			presc_r <= 12'h000;
			count_o <= 12'h000;
			expired_o <= 1'h0;
		end else if (ce_i) begin
			presc_r <= (step || !en_i) ? TIMER_PRESC_CYC - 12'h001 : presc_r - 12'h001;
			expired_o <= step && (count_o == 12'h000);
			if (load_i) begin
				count_o <= reload_i;
			end else if (step) begin
				count_o <= (count_o == 12'h000) ? reload_i : count_o - 12'h001;
			end
		end
	end
endmodule // mubk_timer

/* File: core/mubk_core.sv */
// Banked register window, mode control and word serial engine of the serial module.
// Assumes a host port with one-cycle strobes and asynchronous serial and infrared pins.
module mubk_core
	import mubk_pkg::*;
#(
	parameter logic [7:0] REVISION_ID = 8'h5a // Arbitrary value.
) (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire mubk_pkg::mubk_addr_t addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	input wire logic uart_rxd_i,
	output logic uart_txd_o,
	input wire logic ir_rxd_i,
	output logic ir_txd_o
);
	import mubk_pkg::*;

	logic [2:0] bank_r;
	logic ext_r;
	mubk_mode_t mode_r;
	logic ext_mod_r;
	logic fifo_en_r;
	logic depth32_r;
	logic [3:0] lcr_r;
	logic [7:0] scratch_r;
	logic [15:0] div_r;
	logic tmr_en_r;
	logic [11:0] tmr_reload_r;
	logic [11:0] flen_r;
	logic [7:0] ir_cfg_r [3];
	logic ovr_r;
	logic perr_r;
	logic ferr_r;
	logic tmr_flag_r;
	logic [11:0] tmr_count;
	logic tmr_expired;

	mubk_fifo_if txf();
	mubk_fifo_if rxf();

	// Address decode; bank_r is used as is, so a new selection governs the next access.
	wire is_bsr = addr_i == OFS_BANK_SEL;
	wire wr_reg = wr_i && !is_bsr;
	wire rd_reg = rd_i && !is_bsr;
	wire b_main = bank_r == BANK_MAIN;
	wire b_legacy = bank_r == BANK_LEGACY;
	wire b_ext = bank_r == BANK_EXT;
	wire b_timer = bank_r == BANK_TIMER;
	wire ir_mode = mode_r != MODE_UART;
	wire tmr_ok = ext_r || ir_mode;
	wire word_mode = (mode_r == MODE_UART) || (mode_r == MODE_ASK) || (mode_r == MODE_SIR);
	wire wr_data = wr_reg && b_main && (addr_i == OFS_DATA);
	wire wr_mode = wr_reg && b_main && (addr_i == OFS_MODE);
	wire wr_fifo = wr_reg && b_main && (addr_i == OFS_FIFO_CTL);
	wire wr_lcr = wr_reg && b_main && (addr_i == OFS_LINE_CTL);
	wire wr_scr = wr_reg && b_main && (addr_i == OFS_SCRATCH);
	wire div_ofs = (addr_i == OFS_DIV_LO) || (addr_i == OFS_DIV_HI);
	wire wr_div_legacy = wr_reg && b_legacy && div_ofs;
	wire wr_div = (wr_div_legacy || (wr_reg && b_ext && div_ofs));
	wire wr_tmr = wr_reg && b_timer && tmr_ok;
	wire wr_ir_cfg = wr_reg && (bank_r >= BANK_IRCTL) && (addr_i == OFS_IR_CFG);
	wire [2:0] ir_idx = bank_r - BANK_IRCTL;
	wire rd_data = rd_reg && b_main && (addr_i == OFS_DATA);
	wire rd_stat = rd_reg && b_main && (addr_i == OFS_LINE_STAT);
	wire [2:0] mode_req = wdata_i[MODE_SEL_HI:MODE_SEL_LO];
	wire mode_ok = mode_req <= MODE_CIR;

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			bank_r <= RST_BANK;
			ext_r <= 1'h0;
			mode_r <= MODE_UART;
			ext_mod_r <= 1'h0;
			fifo_en_r <= 1'h0;
			depth32_r <= 1'h0;
		end else if (ce_i) begin
			if (wr_i && is_bsr) begin
				bank_r <= wdata_i[2:0];
			end
			if (wr_mode) begin
				ext_r <= wdata_i[MODE_EXT_BIT];
				mode_r <= mode_ok ? mubk_mode_t'(mode_req) : MODE_UART;
				ext_mod_r <= wdata_i[MODE_EXTMOD_BIT];
			end else if (wr_div_legacy) begin
				ext_r <= 1'h0;
				mode_r <= MODE_UART;
			end
			if (wr_fifo) begin
				fifo_en_r <= wdata_i[FIFO_EN_BIT];
				depth32_r <= wdata_i[FIFO_DEPTH_BIT];
			end
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			lcr_r <= RST_LCR;
			scratch_r <= 8'h00;
			div_r <= RST_DIV;
			tmr_en_r <= 1'h0;
			tmr_reload_r <= 12'h000;
			flen_r <= 12'h000;
			ir_cfg_r <= '{default: 8'h00};
		end else if (ce_i) begin
			if (wr_lcr) lcr_r <= wdata_i[3:0];
			if (wr_scr) scratch_r <= wdata_i;
			if (wr_div && (addr_i == OFS_DIV_LO)) div_r[7:0] <= wdata_i;
			if (wr_div && (addr_i == OFS_DIV_HI)) div_r[15:8] <= wdata_i;
			if (wr_tmr && (addr_i == OFS_TMR_LO)) tmr_reload_r[7:0] <= wdata_i;
			if (wr_tmr && (addr_i == OFS_TMR_HI)) tmr_reload_r[11:8] <= wdata_i[3:0];
			if (wr_tmr && (addr_i == OFS_TMR_CTL)) tmr_en_r <= wdata_i[TMR_EN_BIT];
			if (wr_tmr && (addr_i == OFS_FLEN_LO)) flen_r[7:0] <= wdata_i;
			if (wr_tmr && (addr_i == OFS_FLEN_HI)) flen_r[11:8] <= wdata_i[3:0];
			if (wr_ir_cfg) ir_cfg_r[ir_idx[1:0]] <= wdata_i;
		end
	end

	// The timer loads on the high byte so both halves of a reload land together.
	// Automatic reloads on expiry take the stored value, not the live bus data.
	wire tmr_load = wr_tmr && (addr_i == OFS_TMR_HI);
	wire [11:0] tmr_reload = tmr_load ? {wdata_i[3:0], tmr_reload_r[7:0]} : tmr_reload_r;
	mubk_timer u_timer (
		.sys_clk_i(sys_clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.en_i(tmr_en_r && tmr_ok),
		.load_i(tmr_load),
		.reload_i(tmr_reload),
		.count_o(tmr_count),
		.expired_o(tmr_expired)
	);

	// Baud generator; the floor keeps each mode within its highest rate.
	logic [15:0] baud_cnt_r;
	wire [15:0] div_floor = ext_r ? DIV_MIN_EXT : DIV_MIN_LEGACY;
	wire [15:0] eff_div = (div_r < div_floor) ? div_floor : div_r;
	wire baud_tick = baud_cnt_r == 16'h0000;
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) baud_cnt_r <= 16'h0000;
		else if (ce_i) baud_cnt_r <= baud_tick ? eff_div - 16'h0001 : baud_cnt_r - 16'h0001;
	end

	// Pin synchronisers: bit 0 wired receive, bit 1 infrared receive.
	logic [1:0] s1_r;
	logic [1:0] s2_r;
	logic [1:0] s3_r;
	logic [1:0] filt_r;
	wire [1:0] agree = ~(s2_r ^ s3_r);
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			s1_r <= SYNC_IDLE;
			s2_r <= SYNC_IDLE;
			s3_r <= SYNC_IDLE;
			filt_r <= SYNC_IDLE;
		end else if (ce_i) begin
			s1_r <= {ir_rxd_i, uart_rxd_i};
			s2_r <= s1_r;
			s3_r <= s2_r;
			filt_r <= (s2_r & agree) | (filt_r & ~agree);
		end
	end

	// 500 kHz carrier for internal amplitude keying and the consumer output.
	logic [4:0] car_cnt_r;
	logic car_r;
	wire car_flip = car_cnt_r == (ASK_HALF_CYC - 5'h01);
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			car_cnt_r <= 5'h00;
			car_r <= 1'h0;
		end else if (ce_i) begin
			car_cnt_r <= car_flip ? 5'h00 : car_cnt_r + 5'h01;
			car_r <= car_r ^ car_flip;
		end
	end

	// Transmitter.
	mubk_ser_state_t tx_st_r;
	mubk_ser_state_t tx_st_nxt;
	logic [3:0] tx_sub_r;
	logic [2:0] tx_idx_r;
	logic [7:0] tx_sh_r;
	logic tx_par_r;
	wire [2:0] last_idx = LAST_IDX_MIN + {1'h0, lcr_r[LCR_WL_HI:0]};
	wire tx_busy = tx_st_r != ST_IDLE;
	wire tx_load = !tx_busy && !txf.empty && word_mode;
	wire tx_end = baud_tick && (tx_sub_r == LAST_TICK);
	always_comb begin
		tx_st_nxt = tx_st_r;
		case (tx_st_r)
			ST_IDLE: if (tx_load) tx_st_nxt = ST_START;
			ST_START: if (tx_end) tx_st_nxt = ST_DATA;
			ST_DATA: if (tx_end && (tx_idx_r == last_idx)) begin
				tx_st_nxt = lcr_r[LCR_PEN_BIT] ? ST_PARITY : ST_STOP;
			end
			ST_PARITY: if (tx_end) tx_st_nxt = ST_STOP;
			ST_STOP: if (tx_end) tx_st_nxt = ST_IDLE;
			default: tx_st_nxt = ST_IDLE;
		endcase
	end
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			tx_st_r <= ST_IDLE;
			tx_sub_r <= 4'h0;
			tx_idx_r <= 3'h0;
			tx_sh_r <= 8'h00;
			tx_par_r <= 1'h0;
		end else if (ce_i) begin
			tx_st_r <= tx_st_nxt;
			if (tx_load) begin
				tx_sh_r <= txf.rdata;
				tx_par_r <= ~lcr_r[LCR_EPS_BIT];
				tx_idx_r <= 3'h0;
				tx_sub_r <= 4'h0;
			end else if (baud_tick && tx_busy) begin
				tx_sub_r <= tx_sub_r + 4'h1;
				if (tx_end && (tx_st_r == ST_DATA)) begin
					tx_sh_r <= {1'h0, tx_sh_r[7:1]};
					tx_par_r <= tx_par_r ^ tx_sh_r[0];
					tx_idx_r <= tx_idx_r + 3'h1;
				end
			end
		end
	end
	wire tx_level = (tx_st_r == ST_START) ? 1'h0 : (tx_st_r == ST_DATA) ? tx_sh_r[0] :
		(tx_st_r == ST_PARITY) ? tx_par_r : 1'h1;
	wire ir_zero = !tx_level;
	wire ir_tx_w = (mode_r == MODE_ASK) ? (ir_zero && (ext_mod_r || car_r)) :
		(mode_r == MODE_SIR) ? (ir_zero && (tx_sub_r < SIR_PULSE_TICKS)) :
		(mode_r == MODE_CIR) ? (ir_cfg_r[CIR_IDX][CIR_TX_BIT] && car_r) : 1'h0;

	// Receiver; in SIR and in ASK without ext_mod_r a received pulse stands for one zero bit time.
	logic [4:0] str_r;
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) str_r <= 5'h00;
		else if (ce_i && filt_r[1]) str_r <= STRETCH_TICKS;
		else if (ce_i && baud_tick && (str_r != 5'h00)) str_r <= str_r - 5'h01;
	end
	wire rx_line = (mode_r == MODE_UART) ? filt_r[0] :
		(ext_mod_r && (mode_r == MODE_ASK)) ? !filt_r[1] : (str_r == 5'h00);
	// Infrared links cannot hear themselves, so reception waits while sending.
	wire rx_block = ir_mode && tx_busy;
	mubk_ser_state_t rx_st_r;
	mubk_ser_state_t rx_st_nxt;
	logic [3:0] rx_sub_r;
	logic [2:0] rx_idx_r;
	logic [7:0] rx_sh_r;
	logic rx_par_r;
	wire rx_sample = baud_tick && (rx_sub_r == ((rx_st_r == ST_START) ? MID_TICK : LAST_TICK));
	wire rx_done = rx_sample && (rx_st_r == ST_STOP);
	wire [7:0] rx_word = rx_sh_r >> (3'h7 - last_idx);
	always_comb begin
		rx_st_nxt = rx_st_r;
		case (rx_st_r)
			ST_IDLE: if (!rx_line && word_mode && !rx_block) rx_st_nxt = ST_START;
			ST_START: if (rx_sample) rx_st_nxt = rx_line ? ST_IDLE : ST_DATA;
			ST_DATA: if (rx_sample && (rx_idx_r == last_idx)) begin
				rx_st_nxt = lcr_r[LCR_PEN_BIT] ? ST_PARITY : ST_STOP;
			end
			ST_PARITY: if (rx_sample) rx_st_nxt = ST_STOP;
			ST_STOP: if (rx_sample) rx_st_nxt = ST_IDLE;
			default: rx_st_nxt = ST_IDLE;
		endcase
	end
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			rx_st_r <= ST_IDLE;
			rx_sub_r <= 4'h0;
			rx_idx_r <= 3'h0;
			rx_sh_r <= 8'h00;
			rx_par_r <= 1'h0;
		end else if (ce_i) begin
			rx_st_r <= rx_st_nxt;
			if (rx_st_r == ST_IDLE) begin
				rx_sub_r <= 4'h0;
				rx_idx_r <= 3'h0;
				rx_par_r <= ~lcr_r[LCR_EPS_BIT];
			end else if (baud_tick) begin
				rx_sub_r <= rx_sample ? 4'h0 : rx_sub_r + 4'h1;
				if (rx_sample && (rx_st_r == ST_DATA)) begin
					rx_sh_r <= {rx_line, rx_sh_r[7:1]};
					rx_idx_r <= rx_idx_r + 3'h1;
				end
				if (rx_sample && ((rx_st_r == ST_DATA) || (rx_st_r == ST_PARITY))) begin
					rx_par_r <= rx_par_r ^ rx_line;
				end
			end
		end
	end

	// Error flags: a new event wins over the clear caused by a status read.
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			ovr_r <= 1'h0;
			perr_r <= 1'h0;
			ferr_r <= 1'h0;
			tmr_flag_r <= 1'h0;
		end else if (ce_i) begin
			ovr_r <= (rx_done && rxf.full) || (ovr_r && !rd_stat);
			perr_r <= (rx_done && lcr_r[LCR_PEN_BIT] && rx_par_r) || (perr_r && !rd_stat);
			ferr_r <= (rx_done && !rx_line) || (ferr_r && !rd_stat);
			tmr_flag_r <= tmr_expired || (tmr_flag_r && !rd_stat);
		end
	end

	assign txf.push = wr_data;
	assign txf.pop = tx_load;
	assign txf.clr = wr_fifo && wdata_i[FIFO_TXCLR_BIT];
	assign txf.enable = fifo_en_r;
	assign txf.depth32 = depth32_r;
	assign txf.wdata = wdata_i;
	assign rxf.push = rx_done && !rxf.full;
	assign rxf.pop = rd_data;
	assign rxf.clr = wr_fifo && wdata_i[FIFO_RXCLR_BIT];
	assign rxf.enable = fifo_en_r;
	assign rxf.depth32 = depth32_r;
	assign rxf.wdata = rx_word;
	mubk_fifo u_txf (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .ce_i(ce_i), .fifo(txf));
	mubk_fifo u_rxf (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .ce_i(ce_i), .fifo(rxf));

	// Read selection.
	wire [7:0] stat_w = {1'h0, txf.empty && !tx_busy, txf.empty, tmr_flag_r, ferr_r, perr_r,
		ovr_r, !rxf.empty};
	wire [7:0] div_rd = (addr_i == OFS_DIV_LO) ? div_r[7:0] :
		(addr_i == OFS_DIV_HI) ? div_r[15:8] : 8'h00;
	logic [7:0] bank_rd [8];
	assign bank_rd[0] = (addr_i == OFS_DATA) ? rxf.rdata :
		(addr_i == OFS_MODE) ? {3'h0, ext_mod_r, mode_r, ext_r} :
		(addr_i == OFS_FIFO_CTL) ? {2'h0, depth32_r, 4'h0, fifo_en_r} :
		(addr_i == OFS_LINE_CTL) ? {4'h0, lcr_r} :
		(addr_i == OFS_LINE_STAT) ? stat_w :
		(addr_i == OFS_SCRATCH) ? scratch_r : 8'h00;
	assign bank_rd[1] = div_rd;
	assign bank_rd[2] = div_rd;
	assign bank_rd[3] = (addr_i == OFS_REV) ? REVISION_ID :
		(addr_i == OFS_LINE_STAT) ? stat_w : 8'h00;
	assign bank_rd[4] = !tmr_ok ? 8'h00 :
		(addr_i == OFS_TMR_LO) ? tmr_count[7:0] :
		(addr_i == OFS_TMR_HI) ? {4'h0, tmr_count[11:8]} :
		(addr_i == OFS_TMR_CTL) ? {7'h00, tmr_en_r} :
		(addr_i == OFS_FLEN_LO) ? flen_r[7:0] :
		(addr_i == OFS_FLEN_HI) ? {4'h0, flen_r[11:8]} : 8'h00;
	assign bank_rd[5] = (addr_i == OFS_IR_CFG) ? ir_cfg_r[0] : 8'h00;
	assign bank_rd[6] = (addr_i == OFS_IR_CFG) ? ir_cfg_r[1] : 8'h00;
	assign bank_rd[7] = (addr_i == OFS_IR_CFG) ? ir_cfg_r[CIR_IDX] :
		(addr_i == OFS_CIR_STAT) ? {7'h00, filt_r[1]} : 8'h00;
	wire [7:0] rd_mux = is_bsr ? {5'h00, bank_r} : bank_rd[bank_r];

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			rdata_o <= 8'h00;
			uart_txd_o <= 1'h1;
			ir_txd_o <= 1'h0;
		end else if (ce_i) begin
			rdata_o <= rd_i ? rd_mux : 8'h00;
			uart_txd_o <= (mode_r == MODE_UART) ? tx_level : 1'h1;
			ir_txd_o <= ir_tx_w;
		end
	end
endmodule // mubk_core

/* File: verif/mubk_core_properties.sv */
// Checker of the bank window and the serial pin levels of mubk_core.
// Assumes it is bound to mubk_core and sees only the ports of that module.
module mubk_core_properties
	import mubk_pkg::*;
#(
	parameter logic [7:0] REVISION_ID = 8'h5a
) (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire mubk_pkg::mubk_addr_t addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [7:0] rdata_o,
	input wire logic uart_rxd_i,
	input wire logic uart_txd_o,
	input wire logic ir_rxd_i,
	input wire logic ir_txd_o
);
	logic [2:0] bank_r;
	logic [2:0] mode_r;
	logic ext_r;
	wire logic wr_go = ce_i && wr_i;
	wire logic rd_go = ce_i && rd_i;
	wire logic uart_m = (mode_r == MODE_UART) || (mode_r > MODE_CIR);
	wire logic dark_m = uart_m || (mode_r == MODE_MIR) || (mode_r == MODE_FIR);
	wire logic fall_back = wr_go && (bank_r == BANK_LEGACY) && (addr_i <= OFS_DIV_HI);
	wire logic mode_wr = wr_go && (bank_r == BANK_MAIN) && (addr_i == OFS_MODE);
	// Shadow of bank and mode, so reads can be judged without the design's state.
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			bank_r <= RST_BANK;
			mode_r <= MODE_UART;
			ext_r <= 1'b0;
		end else if (fall_back) begin
			mode_r <= MODE_UART;
			ext_r <= 1'b0;
		end else if (mode_wr) begin
			mode_r <= wdata_i[MODE_SEL_HI:MODE_SEL_LO];
			ext_r <= wdata_i[MODE_EXT_BIT];
		end else if (wr_go && addr_i == OFS_BANK_SEL) begin
			bank_r <= wdata_i[2:0];
		end
	end
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	AST_RDATA_QUIET: assert property (ce_i && !rd_i |=> rdata_o == 8'h00)
		else $error("read data not zero outside a read answer");
	AST_BANK_ECHO: assert property (rd_go && addr_i == OFS_BANK_SEL
		|=> rdata_o == {5'h00, $past(bank_r)}) else $error("bank select read wrong");
	AST_RESET_IDLE: assert property ($fell(rst_i) |-> uart_txd_o && !ir_txd_o)
		else $error("pins not idle after reset");
	AST_REV_CODE: assert property (rd_go && bank_r == BANK_REV && addr_i == OFS_REV
		|=> rdata_o == REVISION_ID) else $error("revision code wrong");
	AST_TIMER_LOCK: assert property (rd_go && bank_r == BANK_TIMER && !ext_r && uart_m
		&& addr_i != OFS_BANK_SEL |=> rdata_o == 8'h00) else $error("timer bank open");
	AST_TXD_PARKED: assert property (!uart_m && $past(!uart_m) |-> uart_txd_o)
		else $error("wired output active outside wired mode");
	AST_IR_DARK: assert property (dark_m && $past(dark_m) |-> !ir_txd_o)
		else $error("infrared output lit in dark mode");
	AST_START_BIT: assert property (uart_m && $fell(uart_txd_o) |-> !uart_txd_o [*8])
		else $error("start bit too short");
endmodule // mubk_core_properties

bind mubk_core mubk_core_properties #(.REVISION_ID(REVISION_ID)) i_mubk_core_properties (
	.sys_clk_i(sys_clk_i), .rst_i(rst_i), .ce_i(ce_i), .addr_i(addr_i), .wdata_i(wdata_i),
	.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .uart_rxd_i(uart_rxd_i),
	.uart_txd_o(uart_txd_o), .ir_rxd_i(ir_rxd_i), .ir_txd_o(ir_txd_o));

/* File: verif/mubk_peer.sv */
// Remote wired modem: sends bytes to the receive pin and decodes the transmit pin.
// Assumes eight data bits, no parity, one stop bit and BIT_CYC clocks a bit.
module mubk_peer #(
	parameter int BIT_CYC = 192
) (
	input wire logic sys_clk_i,
	input wire logic txd_i,
	output logic rxd_o,
	output logic ird_o,
	output logic [7:0] got_o,
	output logic got_v_o
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		rxd_o = 1'b1;
		ird_o = 1'b0;
		got_o = 8'h00;
		got_v_o = 1'b0;
	end
	task automatic send(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(posedge sys_clk_i);
			rxd_o <= f[i];
			repeat (BIT_CYC - 1) @(posedge sys_clk_i);
		end
	endtask
	// A byte with a low stop bit is never reported, so the bench times out on it.
	always begin
		@(negedge txd_i);
		repeat (BIT_CYC / 2) @(posedge sys_clk_i);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT_CYC) @(posedge sys_clk_i);
			got_o[i] <= txd_i;
		end
		repeat (BIT_CYC) @(posedge sys_clk_i);
		got_v_o <= txd_i;
		@(posedge sys_clk_i);
		got_v_o <= 1'b0;
	end
endmodule // mubk_peer

/* File: verif/mubk_core_tb.sv */
// Self-checking bench of mubk_core: bank window, revision, fallback and serial bytes.
// Assumes the reset settings of the core and a modem model on the wired pins.
module mubk_core_tb
	import mubk_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [7:0] REV = 8'h3c; // Arbitrary value.
	localparam int BIT_CYC = 16 * int'(RST_DIV);
	logic sys_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic ce_i = 1'b1;
	mubk_addr_t addr_i = 3'h0;
	logic [7:0] wdata_i = 8'h00;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic [7:0] rdata_o;
	logic uart_rxd_i;
	logic uart_txd_o;
	logic ir_rxd_i;
	logic ir_txd_o;
	logic [7:0] got;
	logic got_v;
	logic rd_seen = 1'b0;
	logic [7:0] exp_q[$];
	logic [7:0] ser_q[$];
	logic [7:0] r1;
	logic [7:0] r2;
	int num_errors = 0;
	int n_checks = 0;
	initial begin
		forever #25 sys_clk_i = ~sys_clk_i;
	end
	mubk_core #(.REVISION_ID(REV)) i_mubk_core (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
		.ce_i(ce_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
		.rdata_o(rdata_o), .uart_rxd_i(uart_rxd_i), .uart_txd_o(uart_txd_o),
		.ir_rxd_i(ir_rxd_i), .ir_txd_o(ir_txd_o));
	mubk_peer #(.BIT_CYC(BIT_CYC)) i_mubk_peer (.sys_clk_i(sys_clk_i), .txd_i(uart_txd_o),
		.rxd_o(uart_rxd_i), .ird_o(ir_rxd_i), .got_o(got), .got_v_o(got_v));
	task automatic chk_reg(input logic [7:0] e, input logic [7:0] s);
		n_checks++;
		if (s !== e) begin
			num_errors++;
			$display("unexpected rdata_o: expected %h seen %h", e, s);
		end
	endtask
	task automatic chk_ser(input logic [7:0] e, input logic [7:0] s);
		n_checks++;
		if (s !== e) begin
			num_errors++;
			$display("unexpected serial byte: expected %h seen %h", e, s);
		end
	endtask
	always @(posedge sys_clk_i) begin
		if (rd_seen) chk_reg(exp_q.pop_front(), rdata_o);
		if (got_v) chk_ser(ser_q.pop_front(), got);
		rd_seen <= rd_i;
	end
	task automatic wr(input mubk_addr_t a, input logic [7:0] d);
		@(posedge sys_clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		rd_i <= 1'b0;
	endtask
	task automatic rd(input mubk_addr_t a, input logic [7:0] e);
		@(posedge sys_clk_i);
		addr_i <= a;
		exp_q.push_back(e);
		wr_i <= 1'b0;
		rd_i <= 1'b1;
	endtask
	task automatic sel(input logic [2:0] b);
		wr(OFS_BANK_SEL, {5'h00, b});
	endtask
	task automatic idle(input int n);
		@(posedge sys_clk_i);
		wr_i <= 1'b0;
		rd_i <= 1'b0;
		repeat (n) @(posedge sys_clk_i);
	endtask
	task automatic conclude();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		void'($urandom(32'hce26));
		r1 = 8'($urandom());
		r2 = 8'($urandom());
		repeat (10) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		rd(OFS_BANK_SEL, 8'h00);
		rd(OFS_LINE_STAT, 8'h60);
		for (int b = 0; b < 8; b++) begin
			sel(3'(b));
			rd(OFS_BANK_SEL, 8'(b));
		end
		rd(3'h6, 8'h00);
		sel(BANK_REV);
		wr(OFS_REV, ~REV);
		rd(OFS_REV, REV);
		sel(BANK_TIMER);
		wr(OFS_FLEN_LO, r1);
		rd(OFS_FLEN_LO, 8'h00);
		sel(BANK_MAIN);
		wr(OFS_MODE, 8'h01);
		sel(BANK_TIMER);
		wr(OFS_FLEN_LO, r1);
		rd(OFS_FLEN_LO, r1);
		wr(OFS_TMR_LO, r2);
		wr(OFS_TMR_HI, 8'h05);
		rd(OFS_TMR_LO, r2);
		rd(OFS_TMR_HI, 8'h05);
		wr(OFS_TMR_LO, 8'h00);
		wr(OFS_TMR_HI, 8'h00);
		wr(OFS_TMR_CTL, 8'h01);
		rd(OFS_TMR_CTL, 8'h01);
		// A zero reload expires on the first prescaler step and sets status bit four.
		idle(2600);
		wr(OFS_TMR_CTL, 8'h00);
		sel(BANK_LEGACY);
		wr(OFS_DIV_LO, RST_DIV[7:0]);
		sel(BANK_TIMER);
		rd(OFS_FLEN_LO, 8'h00);
		sel(BANK_MAIN);
		rd(OFS_MODE, 8'h00);
		wr(OFS_MODE, 8'h04);
		rd(OFS_MODE, 8'h04);
		wr(OFS_MODE, 8'h00);
		wr(OFS_SCRATCH, r2);
		rd(OFS_SCRATCH, r2);
		// A write while the clock enable is low must leave the scratch byte alone.
		idle(0);
		ce_i <= 1'b0;
		wr(OFS_SCRATCH, ~r2);
		idle(2);
		ce_i <= 1'b1;
		rd(OFS_SCRATCH, r2);
		ser_q.push_back(r1);
		wr(OFS_DATA, r1);
		idle(0);
		fork
			i_mubk_peer.send(r2);
		join_none
		for (int i = 0; i < 12 * BIT_CYC && ser_q.size() > 0; i++) @(posedge sys_clk_i);
		if (ser_q.size() > 0) begin
			num_errors++;
			$display("unexpected serial wait: expected byte %h seen none", r1);
			conclude();
		end
		// One more bit time lets both the stop bits finish.
		repeat (BIT_CYC) @(posedge sys_clk_i);
		sel(BANK_REV);
		rd(OFS_LINE_STAT, 8'h71);
		rd(OFS_LINE_STAT, 8'h71);
		sel(BANK_MAIN);
		rd(OFS_LINE_STAT, 8'h71);
		rd(OFS_LINE_STAT, 8'h61);
		rd(OFS_DATA, r2);
		rd(OFS_LINE_STAT, 8'h60);
		idle(4);
		conclude();
	end
endmodule // mubk_core_tb
